// ### iahi_map.svh
// Purpose: field positions, codes, reset values and timing figures
// Assumes: 100 MHz core clock
// Notes:   times in ns, counts derived in the top module
`ifndef IAHI_MAP_SVH
`define IAHI_MAP_SVH

// core clock period
`define IAHI_CLK_NS     10
// line cycle lengths at 60 Hz and 50 Hz
`define IAHI_LINE60_NS  16667000
`define IAHI_LINE50_NS  20000000
// settle time after a new setup byte
`define IAHI_SETUP_NS   2000000
// longest start-up zero calibration
`define IAHI_AZ_NS      400000000

// conversion setup byte fields
`define IAHI_RES_LSB    0
`define IAHI_LINE_BIT   3
`define IAHI_SEL_LSB    4
// default: 22 bits, 60 Hz, primary input
`define IAHI_SETUP_RST  8'h03

// resolution codes
`define IAHI_RES18      3'h1
`define IAHI_RES20      3'h2
`define IAHI_RES22      3'h3
`define IAHI_RES24      3'h4

// line cycles per integration
`define IAHI_LC18       7'h01
`define IAHI_LC20       7'h04
`define IAHI_LC22       7'h10
`define IAHI_LC24       7'h40

`endif

// ### iahi_pkg.sv
// Purpose: types of the converter control block
// Assumes: iahi_map.svh holds the numbers
// Notes:   state codes written out
package iahi_pkg;

	typedef enum logic [2:0] {
		ST_AZ    = 3'h0,
		ST_IDLE  = 3'h1,
		ST_SETUP = 3'h2,
		ST_INTEG = 3'h3,
		ST_DIV   = 3'h4,
		ST_LOAD  = 3'h5,
		ST_MSB   = 3'h6,
		ST_MID   = 3'h7
	} iahi_state_t;

endpackage : iahi_pkg

// ### iahi_top.sv
// Purpose: control and host interface of an integrating converter
// Assumes: host pins are asynchronous, comparator trip is a level
// Notes:   result is offset binary, right justified in three bytes
`include "iahi_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iahi_top #(
	parameter logic [31:0] LINE60_CYC = 32'(`IAHI_LINE60_NS / `IAHI_CLK_NS),
	parameter logic [31:0] LINE50_CYC = 32'(`IAHI_LINE50_NS / `IAHI_CLK_NS),
	parameter logic [31:0] SETUP_CYC  = 32'(`IAHI_SETUP_NS / `IAHI_CLK_NS),
	parameter logic [31:0] AZ_CYC     = 32'(`IAHI_AZ_NS / `IAHI_CLK_NS)
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	input  wire logic       CONVERT_N,
	input  wire logic       OE_N,
	input  wire logic       MODE_CTL,
	input  wire logic [7:0] DATA_IN,
	input  wire logic       COMP_TRIP,
	output logic      [7:0] DATA_OUT,
	output logic            DATA_OE_N,
	output logic            STATUS_FLAG_HIGH,
	output logic            STATUS_FLAG_LOW,
	output logic            REF_DIR,
	output logic            ZERO_CAL,
	output logic      [1:0] INPUT_SEL
);

	// resolution code to result width
	function automatic logic [4:0] res_bits(input logic [2:0] code);
		case (code)
			`IAHI_RES18: res_bits = 5'h12;
			`IAHI_RES20: res_bits = 5'h14;
			`IAHI_RES24: res_bits = 5'h18;
			default:     res_bits = 5'h16;
		endcase
	endfunction : res_bits
	// resolution code to line cycles
	function automatic logic [6:0] line_cycles(input logic [2:0] code);
		case (code)
			`IAHI_RES18: line_cycles = `IAHI_LC18;
			`IAHI_RES20: line_cycles = `IAHI_LC20;
			`IAHI_RES24: line_cycles = `IAHI_LC24;
			default:     line_cycles = `IAHI_LC22;
		endcase
	endfunction : line_cycles
	// state to status pair, high line first
	function automatic logic [1:0] status_of(input iahi_pkg::iahi_state_t s);
		case (s)
			iahi_pkg::ST_MSB:  status_of = 2'h1;
			iahi_pkg::ST_MID:  status_of = 2'h2;
			iahi_pkg::ST_IDLE: status_of = 2'h3;
			default:           status_of = 2'h0;
		endcase
	endfunction : status_of
	iahi_pkg::iahi_state_t state_r;
	iahi_pkg::iahi_state_t state_nxt;
	logic [11:0] pin_s1_r;
	logic [11:0] pin_s2_r;
	logic [2:0]  pin_d_r;
	logic [7:0]  setup_r;
	logic [31:0] tmr_r;
	logic [31:0] line_cnt_r;
	logic [6:0]  lc_cnt_r;
	logic [31:0] seg_r;
	logic [31:0] rise_acc_r;
	logic [31:0] fall_acc_r;
	logic [33:0] rem_r;
	logic [23:0] q_r;
	logic [4:0]  div_cnt_r;
	logic [23:0] res_r;

	// synchronised pins: convert, enable, mode, comparator, data
	wire        conv_s = pin_s2_r[11];
	wire        oe_s   = pin_s2_r[10];
	wire        mode_s = pin_s2_r[9];
	wire        comp_s = pin_s2_r[8];
	wire [7:0]  data_s = pin_s2_r[7:0];
	// edges seen on the second stage only
	wire        conv_fall = pin_d_r[2] & ~conv_s;
	wire        oe_fall   = pin_d_r[1] & ~oe_s;
	wire        comp_rise = ~pin_d_r[0] & comp_s;
	// setup decode
	wire [2:0]  res_code = setup_r[`IAHI_RES_LSB +: 3];
	wire [4:0]  nbits    = res_bits(res_code);
	wire [6:0]  ncyc     = line_cycles(res_code);
	wire [31:0] line_len = setup_r[`IAHI_LINE_BIT] ? LINE50_CYC : LINE60_CYC;
	// integration period in whole line cycles
	wire        in_integ   = (state_r == iahi_pkg::ST_INTEG);
	wire        line_end   = (line_cnt_r == line_len - 32'h1);
	wire        period_end = in_integ & line_end & (lc_cnt_r == ncyc - 7'h1);
	wire        acc_take   = in_integ & (comp_rise | period_end);

	// a setup byte is taken outside a conversion
	wire        busy       = in_integ | (state_r == iahi_pkg::ST_DIV) | (state_r == iahi_pkg::ST_LOAD);
	wire        setup_take = mode_s & oe_fall & ~busy;

	// timers of calibration and setup settle
	wire        az_end    = (tmr_r == AZ_CYC - 32'h1);
	wire        setup_end = (tmr_r == SETUP_CYC - 32'h1);
	// divider: |rise - fall| scaled over rise + fall
	wire [32:0] sum    = {1'b0, rise_acc_r} + {1'b0, fall_acc_r};
	wire        neg    = fall_acc_r > rise_acc_r;
	wire [32:0] diff   = neg ? {1'b0, fall_acc_r} - {1'b0, rise_acc_r}
	                         : {1'b0, rise_acc_r} - {1'b0, fall_acc_r};
	wire [33:0] rem2   = {rem_r[32:0], 1'b0};
	wire        ge     = rem2 >= {1'b0, sum};
	wire [33:0] rem_nx = ge ? rem2 - {1'b0, sum} : rem2;
	wire [23:0] q_nxt  = {q_r[22:0], ge};
	wire        in_div = (state_r == iahi_pkg::ST_DIV);
	wire        div_it = in_div & (div_cnt_r != 5'h0);
	wire        div_done = div_it & (div_cnt_r == nbits - 5'h1);

	// offset binary: half scale plus or minus the quotient
	wire [23:0] half    = 24'(24'h1 << (nbits - 5'h1));
	wire [23:0] res_nxt = neg ? half - q_nxt : half + q_nxt;

	// bus drive only with enable low and no setup in progress
	wire        drive_nxt = ~oe_s & ~mode_s;
	// conversion sequence
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			iahi_pkg::ST_AZ:
				if (az_end)
					state_nxt = iahi_pkg::ST_IDLE;
			iahi_pkg::ST_IDLE:
				if (conv_fall)
					state_nxt = mode_s ? iahi_pkg::ST_SETUP : iahi_pkg::ST_INTEG;
			iahi_pkg::ST_SETUP:
				if (setup_end)
					state_nxt = iahi_pkg::ST_IDLE;
			iahi_pkg::ST_INTEG:
				if (period_end)
					state_nxt = iahi_pkg::ST_DIV;
			iahi_pkg::ST_DIV:
				if (div_done)
					state_nxt = iahi_pkg::ST_LOAD;
			iahi_pkg::ST_LOAD:
				state_nxt = iahi_pkg::ST_MSB;
			iahi_pkg::ST_MSB:
				if (conv_fall)
					state_nxt = mode_s ? iahi_pkg::ST_SETUP : iahi_pkg::ST_MID;
			iahi_pkg::ST_MID:
				if (conv_fall)
					state_nxt = mode_s ? iahi_pkg::ST_SETUP : iahi_pkg::ST_IDLE;
			default:
				state_nxt = iahi_pkg::ST_AZ;
		endcase
	end

	// pin synchronisers and edge history
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pin_s1_r <= 12'hE00;
			pin_s2_r <= 12'hE00;
			pin_d_r  <= 3'h6;
		end
		else if (CE)
		begin
			pin_s1_r <= {CONVERT_N, OE_N, MODE_CTL, COMP_TRIP, DATA_IN};
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= {conv_s, oe_s, comp_s};
		end
	end

	// state, status and calibration switch
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_r          <= iahi_pkg::ST_AZ;
			STATUS_FLAG_HIGH <= 1'b0;
			STATUS_FLAG_LOW  <= 1'b0;
			ZERO_CAL         <= 1'b1;
			DATA_OE_N        <= 1'b1;
		end
		else if (CE)
		begin
			state_r                             <= state_nxt;
			{STATUS_FLAG_HIGH, STATUS_FLAG_LOW} <= status_of(state_nxt);
			ZERO_CAL                            <= (state_nxt == iahi_pkg::ST_AZ);
			DATA_OE_N                           <= ~drive_nxt;
		end
	end

	// setup byte and input select
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			setup_r   <= `IAHI_SETUP_RST;
			INPUT_SEL <= 2'h0;
		end
		else if (CE)
		begin
			if (setup_take)
				setup_r <= data_s;
			INPUT_SEL <= setup_r[`IAHI_SEL_LSB +: 2];
		end
	end

	// shared timer for calibration and setup settle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			tmr_r <= 32'h0;
		else if (CE)
			tmr_r <= (state_nxt != state_r) ? 32'h0 : tmr_r + 32'h1;
	end

	// line period and line cycle counters
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			line_cnt_r <= 32'h0;
			lc_cnt_r   <= 7'h0;
		end
		else if (CE)
		begin
			if (!in_integ || line_end)
				line_cnt_r <= 32'h0;
			else
				line_cnt_r <= line_cnt_r + 32'h1;
			if (!in_integ)
				lc_cnt_r <= 7'h0;
			else if (line_end)
				lc_cnt_r <= lc_cnt_r + 7'h1;
		end
	end

	// slope direction and slope time accumulation
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			REF_DIR    <= 1'b1;
			seg_r      <= 32'h0;
			rise_acc_r <= 32'h0;
			fall_acc_r <= 32'h0;
		end
		else if (CE)
		begin
			if (state_nxt == iahi_pkg::ST_INTEG && !in_integ)
			begin
				seg_r      <= 32'h0;
				rise_acc_r <= 32'h0;
				fall_acc_r <= 32'h0;
			end
			else if (acc_take)
			begin
				seg_r <= 32'h0;
				if (REF_DIR)
					rise_acc_r <= rise_acc_r + seg_r + 32'h1;
				else
					fall_acc_r <= fall_acc_r + seg_r + 32'h1;
			end
			else if (in_integ)
				seg_r <= seg_r + 32'h1;
			if (in_integ && comp_rise)
				REF_DIR <= ~REF_DIR;
		end
	end

	// restoring divider, one quotient bit per cycle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rem_r     <= 34'h0;
			q_r       <= 24'h0;
			div_cnt_r <= 5'h0;
		end
		else if (CE)
		begin
			if (!in_div)
				div_cnt_r <= 5'h0;
			else
				div_cnt_r <= div_cnt_r + 5'h1;
			if (in_div && div_cnt_r == 5'h0)
			begin
				rem_r <= {1'b0, diff};
				q_r   <= 24'h0;
			end
			else if (div_it)
			begin
				rem_r <= rem_nx;
				q_r   <= q_nxt;
			end
		end
	end

	// result and byte presented on the bus
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			res_r    <= 24'h0;
			DATA_OUT <= 8'h0;
		end
		else if (CE)
		begin
			if (div_done)
			begin
				res_r    <= res_nxt;
				DATA_OUT <= res_nxt[23:16];
			end
			else if (state_r == iahi_pkg::ST_MSB && state_nxt == iahi_pkg::ST_MID)
				DATA_OUT <= res_r[15:8];
			else if (state_r == iahi_pkg::ST_MID && state_nxt == iahi_pkg::ST_IDLE)
				DATA_OUT <= res_r[7:0];
		end
	end

	// checks on the converter behaviour
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	ref_flip_a: assert property (CE && in_integ && comp_rise |=> REF_DIR != $past(REF_DIR))
		else $error("reference direction not reversed on trip");
	conv_start_a: assert property (CE && state_r == iahi_pkg::ST_IDLE && conv_fall && !mode_s
		|=> state_r == iahi_pkg::ST_INTEG && !STATUS_FLAG_HIGH && !STATUS_FLAG_LOW)
		else $error("strobe while ready did not start a conversion");
	busy_low_a: assert property (busy |-> !STATUS_FLAG_HIGH && !STATUS_FLAG_LOW)
		else $error("status lines not low during conversion");
	strobe_ignore_a: assert property (CE && in_integ && conv_fall && !period_end |=> in_integ)
		else $error("strobe disturbed a running conversion");
	msb_first_a: assert property ($rose(STATUS_FLAG_LOW) && !STATUS_FLAG_HIGH
		|-> $past(DATA_OUT) == res_r[23:16] && DATA_OUT == res_r[23:16])
		else $error("top byte not loaded before status rose");
	mid_byte_a: assert property (CE && state_r == iahi_pkg::ST_MSB && conv_fall && !mode_s
		|=> STATUS_FLAG_HIGH && !STATUS_FLAG_LOW && DATA_OUT == res_r[15:8])
		else $error("middle byte or status 10 missing");
	low_byte_a: assert property (CE && state_r == iahi_pkg::ST_MID && conv_fall && !mode_s
		|=> STATUS_FLAG_HIGH && STATUS_FLAG_LOW && DATA_OUT == res_r[7:0])
		else $error("bottom byte or status 11 missing");
	bus_drive_a: assert property (CE |=> DATA_OE_N == ($past(oe_s) || $past(mode_s)))
		else $error("bus drive does not follow output enable");
	setup_load_a: assert property (CE && setup_take |=> setup_r == $past(data_s))
		else $error("setup byte not taken");
	res_range_a: assert property (CE && div_done |=> (res_r >> nbits) == 24'h0)
		else $error("result exceeds selected width");
	zero_cal_a: assert property (state_r == iahi_pkg::ST_AZ |-> ZERO_CAL && !STATUS_FLAG_LOW)
		else $error("calibration switch off during calibration");

endmodule : iahi_top

`default_nettype wire

// ### iahi_host_model.sv
// Purpose: host bus and integrator comparator model
// Assumes: pins change just after the rising clock edge
// Notes:   slope times are counted over the integration window
`timescale 1ns/1ps
`default_nettype none

module iahi_host_model #(
	parameter int K_UP = 7,
	parameter int K_DN = 11
) (
	input  wire logic       CLK,
	input  wire logic [7:0] DATA_OUT,
	input  wire logic       DATA_OE_N,
	input  wire logic       STATUS_FLAG_HIGH,
	input  wire logic       STATUS_FLAG_LOW,
	input  wire logic       REF_DIR,
	output logic      [7:0] DATA_IN,
	output logic            COMP_TRIP
);
	logic [7:0] bus_last_r;
	logic [7:0] dat;
	logic       drv;
	logic       busy_prev;
	logic       dir_prev;
	int         cnt;
	int         win_n;
	int         rise;
	int         fall;
	wire        busy = !STATUS_FLAG_HIGH && !STATUS_FLAG_LOW;

	// bus level: device, host, else drifting away from last value
	assign DATA_IN = !DATA_OE_N ? DATA_OUT : drv ? dat : ~bus_last_r;

	initial
	begin
		bus_last_r = 8'h00;
		dat = 8'h00;
		drv = 1'b0;
		win_n = 0;
		cnt = 0;
		busy_prev = 1'b0;
		dir_prev = 1'b1;
	end

	// trip after a fixed slope time, unequal per direction
	always @(posedge CLK)
	begin
		if (busy && !busy_prev)
		begin
			rise = 0;
			fall = 0;
		end
		if (busy && rise + fall < win_n)
		begin
			if (REF_DIR) rise++;
			else fall++;
		end
		cnt = (REF_DIR != dir_prev || !busy) ? 0 : cnt + 1;
		COMP_TRIP <= busy && cnt >= (REF_DIR ? K_UP : K_DN);
		bus_last_r <= DATA_IN;
		dir_prev = REF_DIR;
		busy_prev = busy;
	end
endmodule : iahi_host_model

`default_nettype wire

// ### tb_integrating_adc_host_interface.sv
// Purpose: self-checking bench of the converter control block
// Assumes: short counts for line, setup and calibration times
// Notes:   expected result from measured slope times
`timescale 1ns/1ps
`default_nettype none

module tb_integrating_adc_host_interface;
	logic       clk;
	logic       rst_n;
	logic       convert_n;
	logic       oe_n;
	logic       mode_ctl;
	logic [7:0] data_in;
	logic       comp_trip;
	logic [7:0] data_out;
	logic       data_oe_n;
	logic       sfh;
	logic       sfl;
	logic       ref_dir;
	logic       zero_cal;
	logic [1:0] input_sel;
	int         error_cnt;
	int         n_compared;
	wire  [1:0] st = {sfh, sfl};
	logic [7:0] setup_tab [4] = '{8'h01, 8'h1A, 8'h0C, 8'h13};

	iahi_top #(.LINE60_CYC(32'h32), .LINE50_CYC(32'h3C), .SETUP_CYC(32'h0A), .AZ_CYC(32'h14)) u_iahi_top (
		.CLK(clk), .RST_N(rst_n), .CE(1'b1), .CONVERT_N(convert_n), .OE_N(oe_n),
		.MODE_CTL(mode_ctl), .DATA_IN(data_in), .COMP_TRIP(comp_trip), .DATA_OUT(data_out),
		.DATA_OE_N(data_oe_n), .STATUS_FLAG_HIGH(sfh), .STATUS_FLAG_LOW(sfl), .REF_DIR(ref_dir),
		.ZERO_CAL(zero_cal), .INPUT_SEL(input_sel)
	);

	iahi_host_model u_iahi_host_model (
		.CLK(clk), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .STATUS_FLAG_HIGH(sfh),
		.STATUS_FLAG_LOW(sfl), .REF_DIR(ref_dir), .DATA_IN(data_in), .COMP_TRIP(comp_trip)
	);

	// free-running core clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wait_st(input logic [1:0] s, input int lim);
		int i;
		for (i = 0; i < lim && st !== s; i++) tick(1);
		if (i == lim)
		begin
			error_cnt++;
			$display("Error status wait expected %0h seen %0h", s, st);
			final_report();
		end
	endtask : wait_st

	task automatic strobe;
		convert_n = 1'b0;
		tick(5);
		convert_n = 1'b1;
		tick(5);
	endtask : strobe

	// program a setup byte in the documented host order
	task automatic t_prog(input logic [7:0] b);
		u_iahi_host_model.dat = b;
		u_iahi_host_model.drv = 1'b1;
		mode_ctl = 1'b1;
		oe_n = 1'b1; // enable high first so that its fall takes the byte
		tick(6);
		oe_n = 1'b0;
		tick(5);
		chk("bus enable in setup", 1, data_oe_n);
		convert_n = 1'b0;
		wait_st(2'b00, 10);
		wait_st(2'b11, 40);
		oe_n = 1'b1;
		tick(4);
		mode_ctl = 1'b0;
		convert_n = 1'b1;
		u_iahi_host_model.drv = 1'b0;
		tick(5);
		chk("input select", b[5:4], input_sel);
		$display("done setup %0h", b);
	endtask : t_prog

	// one conversion and three byte reads, stray strobe mid-way
	task automatic t_conv(input logic [7:0] b);
		int     c;
		int     nb;
		int     n;
		int     rs;
		int     fl;
		longint h;
		longint r;
		nb = 16 + 2 * b[2:0];
		n = (1 << (2 * (b[2:0] - 1))) * (b[3] ? 60 : 50);
		h = 64'd1 << (nb - 1);
		u_iahi_host_model.win_n = n;
		oe_n = 1'b0;
		convert_n = 1'b0;
		wait_st(2'b00, 10);
		for (c = 0; c < 5000 && st === 2'b00; c++)
		begin
			convert_n = !(c >= 20 && c < 26);
			tick(1);
		end
		chk("conversion length ok", 1, c >= n && c <= n + nb + 4);
		if (c == 5000)
			final_report();
		rs = u_iahi_host_model.rise;
		fl = u_iahi_host_model.fall;
		chk("both slopes seen", 1, rs > 0 && fl > 0);
		r = rs >= fl ? h + (rs - fl) * h / (rs + fl) : h - (fl - rs) * h / (rs + fl);
		chk("status top", 2'b01, st);
		chk("bus enable", 0, data_oe_n);
		chk("top byte", r[23:16], data_out);
		strobe();
		chk("status middle", 2'b10, st);
		chk("middle byte", r[15:8], data_out);
		strobe();
		chk("status ready", 2'b11, st);
		chk("bottom byte", r[7:0], data_out);
		chk("input select", b[5:4], input_sel);
		$display("done conversion %0h", b);
	endtask : t_conv

	task automatic t_oe;
		oe_n = 1'b1;
		tick(6);
		chk("bus released", 1, data_oe_n);
		oe_n = 1'b0;
		tick(6);
		chk("bus driven", 0, data_oe_n);
		$display("done output enable");
	endtask : t_oe

	// reset in mid conversion restores the defaults
	task automatic t_rst_mid;
		t_prog(8'h1B);
		convert_n = 1'b0;
		wait_st(2'b00, 10);
		tick(30);
		rst_n = 1'b0;
		tick(3);
		chk("reset calibration", 1, zero_cal);
		chk("reset status", 2'b00, st);
		chk("reset input", 0, input_sel);
		rst_n = 1'b1;
		convert_n = 1'b1;
		wait_st(2'b11, 100);
		t_conv(8'h03);
		$display("done mid reset");
	endtask : t_rst_mid

	// calibration after the first reset release
	task automatic t_startup;
		tick(1);
		chk("start calibration", 1, zero_cal);
		chk("start status", 2'b00, st);
		wait_st(2'b11, 100);
		chk("calibration over", 0, zero_cal);
		$display("done start-up");
	endtask : t_startup

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		convert_n = 1'b1;
		oe_n = 1'b1;
		mode_ctl = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		tick(3);
		rst_n = 1'b1;
		t_startup();
		t_conv(8'h03);
		for (int i = 0; i < 4; i++)
		begin
			t_prog(setup_tab[i]);
			t_conv(setup_tab[i]);
		end
		t_oe();
		t_rst_mid();
		final_report();
	end
endmodule : tb_integrating_adc_host_interface

`default_nettype wire
